// ===== logic/converter_fault_hiccup_supervisor.sv
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
//Behaviour
//RULE1 - peak current flag ends the high-side on-pulse in that cycle
//RULE2 - one runaway current event enters hiccup at once, no filtering
//RULE3 - low feedback enters hiccup 1024 cycles after soft-start ends
//RULE4 - hiccup idles both switches for 32768 half-rate cycles
//RULE5 - hiccup timeout expiry starts a new soft-start sequence
//RULE6 - failed retry switches at half rate for soft-start plus 1024, then hiccup
//RULE7 - reset output releases 1024 switching cycles after output-good rising
//RULE8 - output-good falling drives reset output low at once
//RULE9 - reset output low during thermal shutdown and enable low
//RULE10 - prebiased start keeps both switches off until first on-pulse request
//RULE11 - over-temperature stops switching and enters thermal shutdown
//RULE12 - thermal exit on cooled flag, then full soft-start restart
//RULE13 - startup at half rate until startup fraction reached, then full rate
//RULE14 - synchronise all comparator flags; half-rate clock is switching clock / 2
module converter_fault_hiccup_supervisor #(
    parameter int HICCUP_CYCLES = hiccup_pkg::HICCUP_CYCLES_DEFAULT
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic ce,
    // register port
    input wire logic [hiccup_pkg::ADDR_W-1:0] addr,
    input wire logic [hiccup_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [hiccup_pkg::DATA_W-1:0] rd_data,
    // analog stage inputs, asynchronous
    input wire logic switching_clock,
    input wire logic peak_current_limit,
    input wire logic runaway_current_limit,
    input wire logic feedback_hiccup_threshold,
    input wire logic feedback_good_rising,
    input wire logic feedback_good_falling,
    input wire logic over_temperature,
    input wire logic temperature_cooled,
    input wire logic enable_undervoltage_input,
    input wire logic pwm_on_request,
    input wire logic startup_fraction_reached,
    // power switch drive
    output logic high_side_on,
    output logic low_side_on,
    output logic half_freq_mode,
    // open-drain reset pin, active low
    output logic reset_out_o,
    output logic reset_out_oe,
    // interrupt
    output logic irq
);
    // ----------------------------------------------------------------
    // synchronised inputs
    // ----------------------------------------------------------------
    localparam int NSYNC = 11;
    localparam logic [hiccup_pkg::CNT_W-1:0] HICCUP_TARGET =
        hiccup_pkg::CNT_W'(HICCUP_CYCLES);
    logic [NSYNC-1:0] sync_v;
    logic sw_clk_s, peak_s, runaway_s, fb_low_s, good_rise_s, good_fall_s;
    logic hot_s, cooled_s, enable_s, pwm_req_s, fraction_s;

    // all comparator flags pass two flip-flops before use
    flag_sync #(.WIDTH(NSYNC)) u_sync ( // RULE14
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .ce(ce),
        .async_in({switching_clock, peak_current_limit, runaway_current_limit,
                   feedback_hiccup_threshold, feedback_good_rising,
                   feedback_good_falling, over_temperature, temperature_cooled,
                   enable_undervoltage_input, pwm_on_request,
                   startup_fraction_reached}),
        .sync_out(sync_v)
    );
    assign {sw_clk_s, peak_s, runaway_s, fb_low_s, good_rise_s, good_fall_s,
            hot_s, cooled_s, enable_s, pwm_req_s, fraction_s} = sync_v;

    // ----------------------------------------------------------------
    // switching ticks and half-rate ticks
    // ----------------------------------------------------------------
    logic sw_prev_r, half_ph_r;
    logic sw_tick, half_tick;
    assign sw_tick = sw_clk_s && !sw_prev_r;
    assign half_tick = sw_tick && half_ph_r;

    // edge detect and divide-by-two of the switching clock
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sw_prev_r <= 1'b0;
            half_ph_r <= 1'b0;
        end else if (ce) begin
            sw_prev_r <= sw_clk_s;
            if (sw_tick) begin
                half_ph_r <= !half_ph_r; // RULE14
            end
        end
    end

    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    hiccup_pkg::sup_state_e state_r, state_nxt;
    logic [hiccup_pkg::CNT_W-1:0] ss_len_r;
    logic [hiccup_pkg::IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_ev;
    logic ss_done, post_done, hic_done, rst_done;
    logic rst_rel_r, good_cond, hs_nxt, win_r, started_r;

    // ----------------------------------------------------------------
    // timers
    // ----------------------------------------------------------------
    cycle_counter u_ss_timer (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .ce(ce),
        .clr(state_r != hiccup_pkg::st_softstart),
        .inc(sw_tick),
        .target(ss_len_r),
        .done(ss_done)
    );
    cycle_counter u_post_timer (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .ce(ce),
        .clr(state_r != hiccup_pkg::st_run),
        .inc(sw_tick),
        .target(hiccup_pkg::POST_SS_CYCLES),
        .done(post_done)
    );
    cycle_counter u_hiccup_timer (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .ce(ce),
        .clr(state_r != hiccup_pkg::st_hiccup),
        .inc(half_tick), // RULE4
        .target(HICCUP_TARGET),
        .done(hic_done)
    );
    cycle_counter u_reset_timer (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .ce(ce),
        .clr(!good_cond),
        .inc(sw_tick), // RULE7
        .target(hiccup_pkg::RESET_DELAY_CYCLES),
        .done(rst_done)
    );

    // ----------------------------------------------------------------
    // supervisor state machine
    // ----------------------------------------------------------------
    // next state; thermal first, then enable, then faults
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            hiccup_pkg::st_off: begin
                if (enable_s) begin
                    state_nxt = hiccup_pkg::st_prebias;
                end
            end
            hiccup_pkg::st_prebias: begin
                if (pwm_req_s) begin
                    state_nxt = hiccup_pkg::st_softstart; // RULE10
                end
            end
            hiccup_pkg::st_softstart: begin
                if (runaway_s) begin
                    state_nxt = hiccup_pkg::st_hiccup; // RULE2
                end else if (ss_done) begin
                    state_nxt = hiccup_pkg::st_run;
                end
            end
            hiccup_pkg::st_run: begin
                if (runaway_s) begin
                    state_nxt = hiccup_pkg::st_hiccup; // RULE2
                end else if (post_done && fb_low_s) begin
                    state_nxt = hiccup_pkg::st_hiccup; // RULE3 RULE6
                end
            end
            hiccup_pkg::st_hiccup: begin
                if (hic_done) begin
                    state_nxt = hiccup_pkg::st_prebias; // RULE5
                end
            end
            hiccup_pkg::st_thermal: begin
                if (cooled_s) begin
                    state_nxt = hiccup_pkg::st_off; // RULE12
                end
            end
            default: begin
                state_nxt = hiccup_pkg::st_off;
            end
        endcase
        if (hot_s) begin
            state_nxt = hiccup_pkg::st_thermal; // RULE11
        end else if (!enable_s && state_r != hiccup_pkg::st_thermal) begin
            state_nxt = hiccup_pkg::st_off;
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= hiccup_pkg::st_off;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // switch drive
    // ----------------------------------------------------------------
    logic switching, pulse_slot;
    assign switching = (state_r == hiccup_pkg::st_softstart) ||
                       (state_r == hiccup_pkg::st_run);
    assign pulse_slot = sw_tick && (!half_freq_mode || half_ph_r);
    assign hs_nxt = switching && (state_nxt == state_r) && pwm_req_s &&
                    !peak_s && (win_r || pulse_slot);

    // on-window opens on a pulse slot and closes on peak limit or end of demand
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            win_r <= 1'b0;
        end else if (ce) begin
            if (!switching || peak_s || !pwm_req_s) begin
                win_r <= 1'b0; // RULE1
            end else if (pulse_slot) begin
                win_r <= 1'b1;
            end
        end
    end

    // gate flops; both off outside switching states
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            high_side_on <= 1'b0;
            low_side_on <= 1'b0;
            started_r <= 1'b0;
        end else if (ce) begin
            high_side_on <= hs_nxt; // RULE1 RULE4 RULE11
            if (!switching) begin
                started_r <= 1'b0; // RULE10
            end else if (hs_nxt) begin
                started_r <= 1'b1;
            end
            low_side_on <= switching && started_r && !hs_nxt && !peak_s &&
                           (state_nxt == state_r);
        end
    end

    // half rate from each startup until the startup fraction is reached
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            half_freq_mode <= 1'b1;
        end else if (ce) begin
            if (!switching) begin
                half_freq_mode <= 1'b1; // RULE6 RULE13
            end else if (fraction_s) begin
                half_freq_mode <= 1'b0; // RULE13
            end
        end
    end

    // ----------------------------------------------------------------
    // reset output
    // ----------------------------------------------------------------
    assign good_cond = good_rise_s && !good_fall_s && enable_s && !hot_s &&
                       (state_r != hiccup_pkg::st_thermal);

    // pin is driven low unless released; low again with no delay
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_rel_r <= 1'b0;
            reset_out_oe <= 1'b1;
            reset_out_o <= 1'b0;
        end else if (ce) begin
            reset_out_o <= 1'b0;
            if (!good_cond) begin
                rst_rel_r <= 1'b0; // RULE8 RULE9
                reset_out_oe <= 1'b1;
            end else if (rst_done) begin
                rst_rel_r <= 1'b1; // RULE7
                reset_out_oe <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    always_comb begin
        irq_ev = '0;
        irq_ev[hiccup_pkg::IRQ_PEAK] = switching && peak_s && win_r;
        irq_ev[hiccup_pkg::IRQ_RUNAWAY] = switching && runaway_s;
        irq_ev[hiccup_pkg::IRQ_HICCUP] = (state_nxt == hiccup_pkg::st_hiccup) &&
                                         (state_r != hiccup_pkg::st_hiccup);
        irq_ev[hiccup_pkg::IRQ_THERMAL] = (state_nxt == hiccup_pkg::st_thermal) &&
                                          (state_r != hiccup_pkg::st_thermal);
        irq_ev[hiccup_pkg::IRQ_RST_LOW] = rst_rel_r && !good_cond;
        irq_ev[hiccup_pkg::IRQ_RST_REL] = !rst_rel_r && good_cond && rst_done;
    end

    // sticky status, write one to clear, a new event wins over the clear
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_stat_r <= '0;
        end else if (ce) begin
            if (wr_en && addr == hiccup_pkg::ADDR_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~wr_data[hiccup_pkg::IRQ_W-1:0]) | irq_ev;
            end else begin
                irq_stat_r <= irq_stat_r | irq_ev;
            end
        end
    end

    // level interrupt from unmasked status
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |((irq_stat_r | irq_ev) & irq_mask_r);
        end
    end

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    // writable registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ss_len_r <= hiccup_pkg::SS_LEN_RESET;
            irq_mask_r <= '0;
        end else if (ce && wr_en) begin
            if (addr == hiccup_pkg::ADDR_SS_LEN) begin
                ss_len_r <= wr_data[hiccup_pkg::CNT_W-1:0];
            end else if (addr == hiccup_pkg::ADDR_IRQ_MASK) begin
                irq_mask_r <= wr_data[hiccup_pkg::IRQ_W-1:0];
            end
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= '0;
        end else if (ce) begin
            rd_data <= '0;
            if (rd_en) begin
                if (addr == hiccup_pkg::ADDR_SS_LEN) begin
                    rd_data[hiccup_pkg::CNT_W-1:0] <= ss_len_r;
                end else if (addr == hiccup_pkg::ADDR_STATUS) begin
                    rd_data[hiccup_pkg::STAT_STATE_LSB +: 6] <= state_r;
                    rd_data[hiccup_pkg::STAT_HALF_FREQ] <= half_freq_mode;
                    rd_data[hiccup_pkg::STAT_RST_REL] <= rst_rel_r;
                    rd_data[hiccup_pkg::STAT_HS] <= high_side_on;
                    rd_data[hiccup_pkg::STAT_LS] <= low_side_on;
                end else if (addr == hiccup_pkg::ADDR_IRQ_STAT) begin
                    rd_data[hiccup_pkg::IRQ_W-1:0] <= irq_stat_r;
                end else if (addr == hiccup_pkg::ADDR_IRQ_MASK) begin
                    rd_data[hiccup_pkg::IRQ_W-1:0] <= irq_mask_r;
                end
            end
        end
    end
endmodule : converter_fault_hiccup_supervisor
`default_nettype wire

// ===== logic/hiccup_pkg.sv
`default_nettype none
package hiccup_pkg;
    // ------------------------
    // register map (byte addresses)
    // ------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] ADDR_SS_LEN = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
    // ------------------------
    // counts, all in switching cycles or half-rate cycles
    // ------------------------
    localparam int CNT_W = 16;
    localparam logic [15:0] SS_LEN_RESET = 16'h0200;
    localparam logic [15:0] POST_SS_CYCLES = 16'h0400;
    localparam logic [15:0] RESET_DELAY_CYCLES = 16'h0400;
    localparam int HICCUP_CYCLES_DEFAULT = 32768;
    // ------------------------
    // interrupt status bits
    // ------------------------
    localparam int IRQ_W = 6;
    localparam int IRQ_PEAK = 0;
    localparam int IRQ_RUNAWAY = 1;
    localparam int IRQ_HICCUP = 2;
    localparam int IRQ_THERMAL = 3;
    localparam int IRQ_RST_LOW = 4;
    localparam int IRQ_RST_REL = 5;
    // ------------------------
    // status register fields
    // ------------------------
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_HALF_FREQ = 8;
    localparam int STAT_RST_REL = 9;
    localparam int STAT_HS = 10;
    localparam int STAT_LS = 11;
    // ------------------------
    // supervisor states
    // ------------------------
    typedef enum logic [5:0] {
        st_off      = 6'h01,
        st_prebias  = 6'h02,
        st_softstart = 6'h04,
        st_run      = 6'h08,
        st_hiccup   = 6'h10,
        st_thermal  = 6'h20
    } sup_state_e;
endpackage : hiccup_pkg
`default_nettype wire

// ===== logic/flag_sync.sv
`timescale 1ns/1ns
`default_nettype none
module flag_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic ce,
    // flags
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // two-stage synchroniser per bit; first stage feeds only the second
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                meta_r[i] <= 1'b0;
                sync_out[i] <= 1'b0;
            end else if (ce) begin
                meta_r[i] <= async_in[i];
                sync_out[i] <= meta_r[i];
            end
        end
    end
endmodule : flag_sync
`default_nettype wire

// ===== logic/cycle_counter.sv
`timescale 1ns/1ns
`default_nettype none
module cycle_counter (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic ce,
    // control
    input wire logic clr,
    input wire logic inc,
    input wire logic [hiccup_pkg::CNT_W-1:0] target,
    // result
    output logic done
);
    logic [hiccup_pkg::CNT_W-1:0] cnt_r;

    // done once the count reaches the target
    assign done = (cnt_r >= target);

    // saturating count of qualified ticks, held at zero while cleared
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= '0;
        end else if (ce) begin
            if (clr) begin
                cnt_r <= '0;
            end else if (inc && !done) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule : cycle_counter
`default_nettype wire

// ===== tb/analog_stage_model.sv
`timescale 1ns/1ns
`default_nettype none
module analog_stage_model (
    // controls from the bench
    input wire logic pwm_go,
    input wire logic overload,
    // comparator and oscillator outputs
    output logic switching_clock,
    output logic pwm_on_request,
    output logic peak_current_limit
);
    // ------------------------
    // free-running 400 ns oscillator, phase unrelated to sys_clk
    // ------------------------
    initial begin
        switching_clock = 1'b0;
        pwm_on_request = 1'b0;
        peak_current_limit = 1'b0;
        #17;
        forever #200 switching_clock = ~switching_clock;
    end

    // on-time demand for 200 ns, peak trip from 100 ns to cycle end
    always @(posedge switching_clock) begin
        pwm_on_request <= pwm_go;
        peak_current_limit <= 1'b0;
        #100 peak_current_limit <= overload;
        #100 pwm_on_request <= 1'b0;
    end
endmodule : analog_stage_model
`default_nettype wire

// ===== tb/supervisor_checker.sv
`timescale 1ns/1ns
`default_nettype none
module supervisor_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // analog flags
    input wire logic peak_current_limit,
    input wire logic runaway_current_limit,
    input wire logic feedback_good_rising,
    input wire logic feedback_good_falling,
    input wire logic over_temperature,
    input wire logic enable_undervoltage_input,
    input wire logic pwm_on_request,
    input wire logic startup_fraction_reached,
    // outputs under watch
    input wire logic high_side_on,
    input wire logic low_side_on,
    input wire logic half_freq_mode,
    input wire logic reset_out_oe
);
    // ------------------------
    // cycles of unbroken output-good condition
    // ------------------------
    logic [11:0] good_cnt_r;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            good_cnt_r <= 12'h000;
        end else if (!feedback_good_rising || feedback_good_falling
                     || !enable_undervoltage_input || over_temperature) begin
            good_cnt_r <= 12'h000;
        end else if (good_cnt_r != 12'hfff) begin
            good_cnt_r <= good_cnt_r + 12'h001;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // ------------------------
    // properties
    // ------------------------
    sequence s_runaway_seen;
        runaway_current_limit [*6];
    endsequence
    sequence s_gates_idle;
        (!high_side_on && !low_side_on) [*8];
    endsequence
    property p_peak_cut;
        peak_current_limit [*5] |-> !high_side_on;
    endproperty
    property p_runaway_stop;
        s_runaway_seen |-> !high_side_on && !low_side_on;
    endproperty
    property p_hiccup_idle;
        s_runaway_seen |=> s_gates_idle;
    endproperty
    property p_release_delay;
        $fell(reset_out_oe) |-> good_cnt_r >= 12'd2040;
    endproperty
    property p_good_fall;
        feedback_good_falling [*5] |-> reset_out_oe;
    endproperty
    property p_enable_low;
        !enable_undervoltage_input [*6] |-> reset_out_oe;
    endproperty
    property p_hot_reset;
        over_temperature [*6] |-> reset_out_oe;
    endproperty
    property p_hot_stop;
        over_temperature [*6] |-> !high_side_on && !low_side_on;
    endproperty
    property p_no_request;
        !pwm_on_request [*6] |-> !high_side_on;
    endproperty
    property p_full_rate;
        $fell(half_freq_mode) |-> startup_fraction_reached && $past(startup_fraction_reached, 2);
    endproperty

    a_peak_cut: assert property (p_peak_cut) else $error("high side on in peak");
    a_runaway_stop: assert property (p_runaway_stop) else $error("switching on runaway");
    a_hiccup_idle: assert property (p_hiccup_idle) else $error("switching in hiccup");
    a_release_delay: assert property (p_release_delay) else $error("early release");
    a_good_fall: assert property (p_good_fall) else $error("reset not low");
    a_enable_low: assert property (p_enable_low) else $error("reset not low, enable");
    a_hot_reset: assert property (p_hot_reset) else $error("reset not low, hot");
    a_hot_stop: assert property (p_hot_stop) else $error("switching while hot");
    a_no_request: assert property (p_no_request) else $error("pulse unrequested");
    a_full_rate: assert property (p_full_rate) else $error("full rate too soon");
endmodule : supervisor_checker
`default_nettype wire

bind converter_fault_hiccup_supervisor supervisor_checker u_chk (.*);

// ===== tb/tb_converter_fault_hiccup_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
module tb_converter_fault_hiccup_supervisor;
    // ------------------------
    // signals
    // ------------------------
    logic sys_clk, reset_n, ce, wr_en, rd_en, irq, pwm_go, overload;
    logic [3:0] addr;
    logic [31:0] wr_data, rd_data, d;
    logic switching_clock, peak_current_limit, pwm_on_request;
    logic runaway_current_limit, feedback_hiccup_threshold, feedback_good_rising;
    logic feedback_good_falling, over_temperature, temperature_cooled;
    logic enable_undervoltage_input, startup_fraction_reached;
    logic high_side_on, low_side_on, half_freq_mode, reset_out_o, reset_out_oe;
    int n_mismatch = 0, checked = 0, cyc = 0;
    typedef struct {logic [3:0] a; logic [31:0] v;} row_s;
    row_s rows [5] = '{'{4'h0, 32'h200}, '{4'h4, 32'h101}, '{4'h8, 32'h0},
                       '{4'hc, 32'h0}, '{4'h2, 32'h0}};

    converter_fault_hiccup_supervisor #(.HICCUP_CYCLES(8)) dut (.*);
    analog_stage_model u_stage (.*);

    // ------------------------
    // clock and timeout
    // ------------------------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_mismatch++;
            finish_test();
        end
    end

    // ------------------------
    // tasks
    // ------------------------
    task automatic finish_test();
        $display("mismatches %0d, checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask : rd
    // poll the state field for at most n reads
    task automatic wst(input logic [5:0] s, input int n);
        for (int i = 0; i < n; i++) begin
            rd(4'h4, d);
            if (d[5:0] === s) break;
        end
        chk(d & 32'h3f, 32'(s));
    endtask : wst
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wt

    // ------------------------
    // main sequence
    // ------------------------
    initial begin
        {reset_n, wr_en, rd_en, pwm_go, overload, runaway_current_limit} = 6'h00;
        {feedback_hiccup_threshold, feedback_good_rising, feedback_good_falling} = 3'h0;
        {over_temperature, temperature_cooled, enable_undervoltage_input} = 3'h0;
        {startup_fraction_reached, ce, addr, wr_data} = {2'h1, 4'h0, 32'h0};
        wt(10);
        chk(32'({reset_out_o, reset_out_oe, irq, half_freq_mode}), 32'h5);
        @(posedge sys_clk) reset_n <= 1'b1;
        foreach (rows[i]) begin
            rd(rows[i].a, d);
            chk(d, rows[i].v);
        end
        wr(4'h0, 32'h4);
        wr(4'hc, 32'h3f);
        @(posedge sys_clk) enable_undervoltage_input <= 1'b1;
        wst(6'h02, 50);
        wt(40);
        chk(32'({high_side_on, low_side_on}), 32'h0);
        @(posedge sys_clk) pwm_go <= 1'b1;
        wst(6'h08, 400);
        chk(32'(half_freq_mode), 32'h1);
        @(posedge sys_clk) startup_fraction_reached <= 1'b1;
        wt(8);
        chk(32'(half_freq_mode), 32'h0);
        @(posedge sys_clk) feedback_good_rising <= 1'b1;
        wt(8100);
        chk(32'(reset_out_oe), 32'h1);
        wt(250);
        chk(32'(reset_out_oe), 32'h0);
        @(posedge sys_clk) feedback_good_falling <= 1'b1;
        wt(5);
        chk(32'({reset_out_oe, irq}), 32'h3);
        rd(4'h8, d);
        chk(d & 32'h30, 32'h30);
        wr(4'hc, 32'h0);
        wt(2);
        chk(32'(irq), 32'h0);
        wr(4'hc, 32'h3f);
        wr(4'h8, 32'h3f);
        wt(2);
        chk(32'(irq), 32'h0);
        @(posedge sys_clk) {feedback_good_falling, overload} <= 2'h1;
        wt(100);
        rd(4'h8, d);
        chk(d & 32'h1, 32'h1);
        @(posedge sys_clk) overload <= 1'b0;
        @(posedge sys_clk) runaway_current_limit <= 1'b1;
        startup_fraction_reached <= 1'b0;
        feedback_hiccup_threshold <= 1'b1;
        wt(5);
        @(posedge sys_clk) runaway_current_limit <= 1'b0;
        wst(6'h10, 3);
        wt(80);
        chk(32'({high_side_on, low_side_on}), 32'h0);
        wst(6'h08, 300);
        wt(7900);
        wst(6'h08, 1);
        chk(32'(half_freq_mode), 32'h1);
        wst(6'h10, 5000);
        @(posedge sys_clk) feedback_hiccup_threshold <= 1'b0;
        startup_fraction_reached <= 1'b1;
        wst(6'h08, 400);
        wt(8400);
        chk(32'(reset_out_oe), 32'h0);
        @(posedge sys_clk) over_temperature <= 1'b1;
        wst(6'h20, 4);
        chk(32'({high_side_on, low_side_on, reset_out_oe}), 32'h1);
        @(posedge sys_clk) over_temperature <= 1'b0;
        wt(20);
        wst(6'h20, 1);
        @(posedge sys_clk) temperature_cooled <= 1'b1;
        wst(6'h08, 400);
        @(posedge sys_clk) temperature_cooled <= 1'b0;
        wt(8400);
        chk(32'(reset_out_oe), 32'h0);
        @(posedge sys_clk) enable_undervoltage_input <= 1'b0;
        wt(6);
        chk(32'(reset_out_oe), 32'h1);
        wst(6'h01, 5);
        finish_test();
    end
endmodule : tb_converter_fault_hiccup_supervisor
`default_nettype wire
